// ==== src/pig_pkg.sv ====
// Purpose: Shared constants for the pulse interrupt generator.
// Assumes: One 32-bit control register reached over an AXI4-Lite slave port.
// Notes:   Bit 0 is the pending flag, bits 31..1 are plain storage.
//
// Overview of operation
// R1 - Tick pulse raises second core interrupt output.
// R2 - Tick source drives pulse synchronous to clock.
// R3 - One 32-bit control register at offset zero.
// R4 - Bits 31..1 store and return written value.
// R5 - Bit 0 mirrors interrupt output level.
// R6 - Tick sets bit 0 regardless of state.
// R7 - Bus write of 1 sets flag.
// R8 - Only bus write of 0 clears flag.
// R9 - Register read/writable over AXI slave port.
// R10 - Second core service routine clears flag.
// R11 - First core may write 1 to interrupt.
// R12 - Tick beats simultaneous clearing write.
// R13 - Reset clears whole register, output low.

package pig_pkg;

    localparam int          PIG_DATA_W      = 32;
    localparam int          PIG_ADDR_W      = 4;
    localparam logic [31:0] PIG_BASE_ADDR   = 32'h7860_0000;
    localparam logic [31:0] PIG_CTRL_OFFSET = 32'h0000_0000;
    localparam int          PIG_FLAG_BIT    = 0;
    localparam logic [31:0] PIG_CTRL_RESET  = 32'h0000_0000;
    localparam logic [1:0]  PIG_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PIG_RESP_SLVERR = 2'h2;

endpackage

// ==== src/pig_flag_cell.sv ====
// Purpose: Pending interrupt flag with set-over-clear priority.
// Assumes: Set pulse is synchronous to clk_in.
// Notes:   The flag register output drives the interrupt pin directly.
`timescale 1ns/1ps
`default_nettype none

module pig_flag_cell
    import pig_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic set_in,
    input  wire logic wr_en_in,
    input  wire logic wr_bit_in,
    output var  logic flag_out
);

    logic flag_q;
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (wr_en_in) begin
            flag_d = wr_bit_in; // R7 R8
        end
        // The pulse is applied last so a request is never lost to a racing clear.
        if (set_in) begin
            flag_d = 1'b1; // R6 R12
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flag_q <= PIG_CTRL_RESET[PIG_FLAG_BIT]; // R13
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_out = flag_q;

endmodule

`default_nettype wire

// ==== src/pig_irq_top.sv ====
// Purpose: Turns a request pulse into a level interrupt with an AXI4-Lite control register.
// Assumes: request_tick_in is synchronous to clk_in; AXI master holds valid until ready.
// Notes:   The interrupt output is active high; invert at the pin if it must be low-true.
`timescale 1ns/1ps
`default_nettype none

module pig_irq_top
    import pig_pkg::*;
#(
    parameter int ADDR_W = PIG_ADDR_W,
    parameter int DATA_W = PIG_DATA_W
) (
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic                request_tick_in,
    output var  logic                second_core_irq_out,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr_in,
    input  wire logic                s_axi_awvalid_in,
    output var  logic                s_axi_awready_out,
    input  wire logic [DATA_W-1:0]   s_axi_wdata_in,
    input  wire logic [DATA_W/8-1:0] s_axi_wstrb_in,
    input  wire logic                s_axi_wvalid_in,
    output var  logic                s_axi_wready_out,
    output var  logic [1:0]          s_axi_bresp_out,
    output var  logic                s_axi_bvalid_out,
    input  wire logic                s_axi_bready_in,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr_in,
    input  wire logic                s_axi_arvalid_in,
    output var  logic                s_axi_arready_out,
    output var  logic [DATA_W-1:0]   s_axi_rdata_out,
    output var  logic [1:0]          s_axi_rresp_out,
    output var  logic                s_axi_rvalid_out,
    input  wire logic                s_axi_rready_in
);

    if (DATA_W != 32) begin : g_bad_data_w
        $error("pig_irq_top serves only a 32-bit data bus");
    end
    if (ADDR_W < 2) begin : g_bad_addr_w
        $error("pig_irq_top needs at least a 2-bit address");
    end

    // Only the control word is mapped; everything else answers with a slave error.
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2] == PIG_CTRL_OFFSET[ADDR_W-1:2];
    endfunction

    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    logic        awready_q;
    logic        awready_d;
    logic        wready_q;
    logic        wready_d;
    logic        bvalid_q;
    logic        bvalid_d;
    logic [1:0]  bresp_q;
    logic [1:0]  bresp_d;
    logic        arready_q;
    logic        arready_d;
    logic        rvalid_q;
    logic        rvalid_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:1] upper_q;
    logic [31:1] upper_d;
    logic        flag;
    logic        wr_fire;
    logic        rd_fire;
    logic        wr_hit;
    logic        flag_wr_en;
    logic [31:0] ctrl_word;
    logic [31:0] merged;

    assign wr_fire    = s_axi_awvalid_in && awready_q && s_axi_wvalid_in && wready_q;
    assign rd_fire    = s_axi_arvalid_in && arready_q;
    assign wr_hit     = addr_hit(s_axi_awaddr_in);
    assign ctrl_word  = {upper_q, flag}; // R5
    assign merged     = apply_strb(ctrl_word, s_axi_wdata_in, s_axi_wstrb_in);
    assign flag_wr_en = wr_fire && wr_hit && s_axi_wstrb_in[0]; // R9

    // Write channel: address and data are taken together in one handshake cycle.
    always_comb begin
        awready_d = 1'b0;
        wready_d  = 1'b0;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        upper_d   = upper_q;
        if (s_axi_awvalid_in && s_axi_wvalid_in && !awready_q && !bvalid_q) begin
            awready_d = 1'b1;
            wready_d  = 1'b1;
        end
        if (wr_fire) begin
            bvalid_d = 1'b1; // R9
            bresp_d  = wr_hit ? PIG_RESP_OKAY : PIG_RESP_SLVERR; // R3
            if (wr_hit) begin
                upper_d = merged[31:1]; // R4
            end
        end else if (bvalid_q && s_axi_bready_in) begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= PIG_RESP_OKAY;
            upper_q   <= PIG_CTRL_RESET[31:1]; // R13
        end else begin
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            upper_q   <= upper_d;
        end
    end

    // Read channel: data is sampled at the address handshake and held until taken.
    always_comb begin
        arready_d = 1'b0;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (s_axi_arvalid_in && !arready_q && !rvalid_q) begin
            arready_d = 1'b1;
        end
        if (rd_fire) begin
            rvalid_d = 1'b1; // R9
            if (addr_hit(s_axi_araddr_in)) begin
                rdata_d = ctrl_word; // R4 R5
                rresp_d = PIG_RESP_OKAY;
            end else begin
                rdata_d = 32'h0000_0000; // R3
                rresp_d = PIG_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready_in) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= PIG_RESP_OKAY;
            rdata_q   <= PIG_CTRL_RESET;
        end else begin
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    // The tick needs no synchroniser because its source shares clk_in.
    pig_flag_cell u_flag (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .set_in    (request_tick_in), // R1 R2
        .wr_en_in  (flag_wr_en),
        .wr_bit_in (s_axi_wdata_in[PIG_FLAG_BIT]),
        .flag_out  (flag)
    );

    assign second_core_irq_out = flag; // R1 R5
    assign s_axi_awready_out   = awready_q;
    assign s_axi_wready_out    = wready_q;
    assign s_axi_bvalid_out    = bvalid_q;
    assign s_axi_bresp_out     = bresp_q;
    assign s_axi_arready_out   = arready_q;
    assign s_axi_rvalid_out    = rvalid_q;
    assign s_axi_rresp_out     = rresp_q;
    assign s_axi_rdata_out     = rdata_q;

    property p_tick_raises;
        @(posedge clk_in) disable iff (rst_in)
        request_tick_in |=> second_core_irq_out;
    endproperty
    a_tick_raises: assert property (p_tick_raises) else $error("tick did not raise irq"); // R1

    property p_write_one_sets;
        @(posedge clk_in) disable iff (rst_in)
        flag_wr_en && s_axi_wdata_in[0] |=> second_core_irq_out;
    endproperty
    a_write_one_sets: assert property (p_write_one_sets) else $error("write 1 did not set"); // R7

    property p_clear_only_by_write;
        @(posedge clk_in) disable iff (rst_in)
        $fell(second_core_irq_out) |-> $past(flag_wr_en && !s_axi_wdata_in[0]
                                             && !request_tick_in);
    endproperty
    a_clear_only_by_write: assert property (p_clear_only_by_write) else $error("bad clear"); // R8

    property p_tick_beats_clear;
        @(posedge clk_in) disable iff (rst_in)
        request_tick_in && flag_wr_en && !s_axi_wdata_in[0] |=> second_core_irq_out[*2];
    endproperty
    a_tick_beats_clear: assert property (p_tick_beats_clear) else $error("tick lost"); // R12

    property p_upper_stores;
        @(posedge clk_in) disable iff (rst_in)
        wr_fire && wr_hit && s_axi_wstrb_in == 4'hf |=> upper_q == $past(s_axi_wdata_in[31:1]);
    endproperty
    a_upper_stores: assert property (p_upper_stores) else $error("upper bits not stored"); // R4

    property p_read_mirrors;
        @(posedge clk_in) disable iff (rst_in)
        rd_fire && addr_hit(s_axi_araddr_in)
            |=> s_axi_rdata_out == $past(ctrl_word) && s_axi_rvalid_out;
    endproperty
    a_read_mirrors: assert property (p_read_mirrors) else $error("read data mismatch"); // R5

    property p_unmapped_read;
        @(posedge clk_in) disable iff (rst_in)
        rd_fire && !addr_hit(s_axi_araddr_in)
            |=> s_axi_rdata_out == 32'h0000_0000 && s_axi_rresp_out == PIG_RESP_SLVERR;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read wrong"); // R3

    property p_write_answer;
        @(posedge clk_in) disable iff (rst_in)
        s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_awready_out && !s_axi_bvalid_out
            |=> s_axi_awready_out && s_axi_wready_out ##1 s_axi_bvalid_out;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write not answered"); // R9

    property p_resp_held;
        @(posedge clk_in) disable iff (rst_in)
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
    endproperty
    a_resp_held: assert property (p_resp_held) else $error("write response dropped"); // R9

    property p_reset_clears;
        @(posedge clk_in)
        rst_in |=> !second_core_irq_out && upper_q == PIG_CTRL_RESET[31:1];
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear"); // R13

endmodule

`default_nettype wire

// ==== bench/pig_host_model.sv ====
// Purpose: Host cores and probe source driving the control register port.
// Assumes: Signals change 1 ns after a rising edge and hold until ready is seen.
// Notes:   Port names mirror the device pins so the bench can join them by name.
`timescale 1ns/1ps
`default_nettype none
module pig_host_model (
    input  wire logic        clk_in,
    output var  logic        request_tick_in,
    output var  logic [3:0]  s_axi_awaddr_in,
    output var  logic        s_axi_awvalid_in,
    input  wire logic        s_axi_awready_out,
    output var  logic [31:0] s_axi_wdata_in,
    output var  logic [3:0]  s_axi_wstrb_in,
    output var  logic        s_axi_wvalid_in,
    input  wire logic        s_axi_wready_out,
    input  wire logic [1:0]  s_axi_bresp_out,
    input  wire logic        s_axi_bvalid_out,
    output var  logic        s_axi_bready_in,
    output var  logic [3:0]  s_axi_araddr_in,
    output var  logic        s_axi_arvalid_in,
    input  wire logic        s_axi_arready_out,
    input  wire logic [31:0] s_axi_rdata_out,
    input  wire logic [1:0]  s_axi_rresp_out,
    input  wire logic        s_axi_rvalid_out,
    output var  logic        s_axi_rready_in
);
    int stall = 0;
    // Counts handshakes that never completed, so a silent hang cannot pass.
    int lost = 0;
    initial begin
        {request_tick_in, s_axi_awaddr_in, s_axi_awvalid_in, s_axi_wdata_in} = '0;
        {s_axi_wstrb_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
        {s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    end
    // One-cycle probe pulse launched just after an edge.
    task automatic tick();
        @(posedge clk_in);
        #1 request_tick_in = 1'b1;
        @(posedge clk_in);
        #1 request_tick_in = 1'b0;
    endtask
    // Either core writes; tk raises a pulse on the handshake edge.
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic tk, output logic [1:0] rsp);
        int n;
        @(posedge clk_in);
        #1 {s_axi_awaddr_in, s_axi_wdata_in, s_axi_wstrb_in} = {a, d, s};
        {s_axi_awvalid_in, s_axi_wvalid_in} = 2'h3;
        n = 0;
        do begin
            @(posedge clk_in);
            #1 n++;
        end while (!(s_axi_awready_out && s_axi_wready_out) && n < 50);
        if (!(s_axi_awready_out && s_axi_wready_out)) lost++;
        request_tick_in = tk;
        @(posedge clk_in);
        #1 {s_axi_awvalid_in, s_axi_wvalid_in, request_tick_in} = 3'h0;
        // Released lines show the inverse so stale data cannot pass for fresh.
        {s_axi_awaddr_in, s_axi_wdata_in} = ~{a, d};
        repeat (stall) begin
            @(posedge clk_in);
            #1;
        end
        s_axi_bready_in = 1'b1;
        n = 0;
        while (!s_axi_bvalid_out && n < 50) begin
            @(posedge clk_in);
            #1 n++;
        end
        if (!s_axi_bvalid_out) lost++;
        rsp = s_axi_bresp_out;
        @(posedge clk_in);
        #1 s_axi_bready_in = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rsp);
        int n;
        @(posedge clk_in);
        #1 {s_axi_araddr_in, s_axi_arvalid_in} = {a, 1'b1};
        n = 0;
        do begin
            @(posedge clk_in);
            #1 n++;
        end while (!s_axi_arready_out && n < 50);
        if (!s_axi_arready_out) lost++;
        @(posedge clk_in);
        #1 {s_axi_araddr_in, s_axi_arvalid_in} = {~a, 1'b0};
        repeat (stall) begin
            @(posedge clk_in);
            #1;
        end
        s_axi_rready_in = 1'b1;
        n = 0;
        while (!s_axi_rvalid_out && n < 50) begin
            @(posedge clk_in);
            #1 n++;
        end
        if (!s_axi_rvalid_out) lost++;
        {d, rsp} = {s_axi_rdata_out, s_axi_rresp_out};
        @(posedge clk_in);
        #1 s_axi_rready_in = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== bench/pulse_irq_generator_bench.sv ====
// Purpose: Self-checking bench for the pulse interrupt generator.
// Assumes: A word model of the control register predicts every read.
// Notes:   Random data and strobes come from a fixed-seed shift register.
`timescale 1ns/1ps
`default_nettype none
module pulse_irq_generator_bench;
    import pig_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    wire  [3:0]  s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in;
    wire  [31:0] s_axi_wdata_in, s_axi_rdata_out;
    wire  [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    wire         request_tick_in, second_core_irq_out, s_axi_awvalid_in, s_axi_awready_out;
    wire         s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
    wire         s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
    int          err_total = 0;
    int          n_checks = 0;
    logic [31:0] lf = 32'hd3b9de26;
    logic [31:0] m, rd;
    logic [1:0]  rsp;
    always #2.5 clk_in = ~clk_in;
    pig_irq_top u_dut (.*);
    pig_host_model u_host (.*);
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        err_total += u_host.lost;
        if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rchk(input logic [3:0] a);
        u_host.rd(a, rd, rsp);
        chk("rdata", rd, (a[3:2] == 2'h0) ? m : 32'h0);
        chk("rresp", 32'(rsp), 32'((a[3:2] == 2'h0) ? PIG_RESP_OKAY : PIG_RESP_SLVERR));
        chk("irq", 32'(second_core_irq_out), 32'(m[0]));
    endtask
    task automatic wchk(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
                        input logic tk);
        u_host.wr(a, v, s, tk, rsp);
        chk("bresp", 32'(rsp), 32'((a[3:2] == 2'h0) ? PIG_RESP_OKAY : PIG_RESP_SLVERR));
        if (a[3:2] == 2'h0)
            for (int b = 0; b < 4; b++)
                if (s[b]) m[8*b+:8] = v[8*b+:8];
        if (tk) m[0] = 1'b1;
        rchk(4'h0);
    endtask
    initial begin
        #20000;
        err_total++;
        final_report();
    end
    initial begin
        m = 32'h0;
        repeat (2) @(posedge clk_in);
        #1 rst_in = 1'b0;
        chk("irq_rst", 32'(second_core_irq_out), 32'h0);
        rchk(4'h0);
        u_host.tick();
        chk("irq_tick", 32'(second_core_irq_out), 32'h1);
        m[0] = 1'b1;
        rchk(4'h0);
        wchk(4'h0, 32'h0, 4'h1, 1'b0);
        wchk(4'h0, 32'h1, 4'h1, 1'b0);
        u_host.tick();
        rchk(4'h0);
        wchk(4'h0, 32'h0, 4'h1, 1'b1);
        for (int i = 0; i < 10; i++) begin
            lf = nx(lf);
            u_host.stall = i % 3;
            wchk(4'h0, lf, lf[7:4], lf[9]);
        end
        for (int a = 4; a < 16; a += 4) begin
            lf = nx(lf);
            wchk(a[3:0], lf, 4'hf, 1'b0);
            rchk(a[3:0]);
        end
        rchk(4'h3);
        @(posedge clk_in);
        #1 rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 rst_in = 1'b0;
        m = 32'h0;
        rchk(4'h0);
        final_report();
    end
endmodule
`default_nettype wire
